// [core/pdc_top.sv]
// power-down control: standby, system control and clock-gate registers
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pdc_top
   import pdc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              hw_standby_n,
   input  wire logic              chip_init_n,
   input  wire logic              watchdog_run,
   input  wire logic              sleep_req,
   input  wire logic              bus_req,
   input  wire logic              bus_write,
   input  wire logic [31:0]       bus_addr,
   input  wire pdc_pkg::pdc_size_t bus_size,
   input  wire logic [15:0]       bus_wdata,
   output logic      [7:0]        bus_rdata,
   output logic                   bus_ack,
   input  wire logic              ram_req,
   input  wire logic              ram_write,
   output logic                   ram_sel,
   output logic                   ram_we,
   output logic                   debug_unit_reset,
   output logic                   debug_clock_en,
   output logic                   break_clock_en,
   output logic                   break_unit_reset,
   output logic                   osc_enable,
   output logic                   hw_standby,
   output logic                   soft_standby,
   output logic                   sleep_mode,
   output logic                   ports_float,
   output logic                   cpu_reset
);
   import pdc_pkg::*;
   pdc_ctl_if ctl ();
   logic [7:0] standby_control;
   logic [7:0] system_control;
   logic [7:0] module_clock_gate;
   logic [7:0] next_standby;
   logic [7:0] next_system;
   logic [7:0] next_gate;
   logic [7:0] next_rdata;
   logic       next_ack;
   logic       hw_standby_s;
   logic       chip_init_s;
   logic       rst_any;
   logic       hit_sby;
   logic       hit_sys;
   logic       hit_gate;
   pdc_pwr_t   pwr_state;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // pins start low so power-up is seen as standby until they settle
   pdc_sync #(.RST_VAL(1'b0)) u_sync_hs (
      .clk  (clk),
      .srst (srst),
      .d    (hw_standby_n),
      .q    (hw_standby_s)
   );
   pdc_sync #(.RST_VAL(1'b0)) u_sync_ci (
      .clk  (clk),
      .srst (srst),
      .d    (chip_init_n),
      .q    (chip_init_s)
   );
   pdc_sequencer u_seq (
      .clk          (clk),
      .srst         (srst),
      .hw_standby_n (hw_standby_s),
      .chip_init_n  (chip_init_s),
      .sleep_req    (sleep_req),
      .ctl          (ctl.seq),
      .osc_enable   (osc_enable),
      .hw_standby   (hw_standby),
      .soft_standby (soft_standby),
      .sleep_mode   (sleep_mode),
      .ports_float  (ports_float),
      .pwr_state    (pwr_state)
   );
   // ----------------------------------------
   // register file
   // ----------------------------------------
   // power-on reset covers both srst and the chip held in standby/init
   assign rst_any  = srst || ctl.in_reset;
   assign hit_sby  = bus_req && (bus_addr == STANDBY_CONTROL_ADDR);
   assign hit_sys  = bus_req && (bus_addr == SYSTEM_CONTROL_ADDR);
   assign hit_gate = bus_req && (bus_addr == MODULE_CLOCK_GATE_ADDR);
   assign ctl.soft_standby_select = standby_control[SOFT_STANDBY_BIT];
   assign ctl.port_float_select   = standby_control[PORT_FLOAT_BIT];
   // next register values from bus writes
   always_comb begin
      next_standby = standby_control;
      next_system  = system_control;
      next_gate    = module_clock_gate;
      if (bus_write && hit_sby) begin
         next_standby = (bus_wdata[7:0] & STANDBY_WRITABLE) | STANDBY_FIXED_ONES;
         if (watchdog_run && bus_wdata[SOFT_STANDBY_BIT]) begin
            next_standby[SOFT_STANDBY_BIT] = standby_control[SOFT_STANDBY_BIT];
         end
         if (watchdog_run && bus_wdata[PORT_FLOAT_BIT]) begin
            next_standby[PORT_FLOAT_BIT] = standby_control[PORT_FLOAT_BIT];
         end
      end
      if (bus_write && hit_sys) begin
         next_system = bus_wdata[7:0] & SYSTEM_WRITABLE;
      end
      if (bus_write && hit_gate && bus_size == PDC_SZ_WORD && bus_wdata[15:8] == GATE_WRITE_KEY) begin
         next_gate = bus_wdata[7:0] & GATE_WRITABLE;
      end
   end
   always_ff @(posedge clk) begin
      if (rst_any) begin
         standby_control   <= STANDBY_CONTROL_RST;
         system_control    <= SYSTEM_CONTROL_RST;
         module_clock_gate <= MODULE_CLOCK_GATE_RST;
      end else begin
         standby_control   <= next_standby;
         system_control    <= next_system;
         module_clock_gate <= next_gate;
      end
   end
   // ----------------------------------------
   // read path
   // ----------------------------------------
   // unmapped reads return zero; ack one cycle after the request
   always_comb begin
      next_rdata = 8'h00;
      next_ack   = bus_req;
      if (!bus_write) begin
         if (hit_sby) begin
            next_rdata = standby_control;
         end else if (hit_sys) begin
            next_rdata = system_control;
         end else if (hit_gate) begin
            next_rdata = module_clock_gate;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_rdata <= 8'h00;
         bus_ack   <= 1'b0;
      end else begin
         bus_rdata <= next_rdata;
         bus_ack   <= next_ack;
      end
   end
   // ----------------------------------------
   // module controls
   // ----------------------------------------
   // debug unit reset
   assign debug_unit_reset = system_control[DEBUG_RESET_BIT] || rst_any;
   assign debug_clock_en = !module_clock_gate[DEBUG_STOP_BIT] && !hw_standby;
   assign break_clock_en   = !module_clock_gate[BREAK_STOP_BIT] && !hw_standby;
   assign break_unit_reset = module_clock_gate[BREAK_STOP_BIT] || rst_any;
   // ram gating, writes dropped when disabled
   assign ram_sel   = ram_req && system_control[RAM_ENABLE_BIT];
   assign ram_we    = ram_sel && ram_write;
   assign cpu_reset = rst_any;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_sby_refuse: assert property (@(posedge clk) disable iff (rst_any)
      (bus_write && hit_sby && watchdog_run && !standby_control[SOFT_STANDBY_BIT])
      |=> !standby_control[SOFT_STANDBY_BIT]) else $error("soft standby set with watchdog running");
   a_float_refuse: assert property (@(posedge clk) disable iff (rst_any)
      (bus_write && hit_sby && watchdog_run && !standby_control[PORT_FLOAT_BIT])
      |=> !standby_control[PORT_FLOAT_BIT]) else $error("port float set with watchdog running");
   a_sby_fixed: assert property (@(posedge clk) disable iff (srst)
      standby_control[5:0] == STANDBY_FIXED_ONES[5:0]) else $error("standby reserved bits wrong");
   a_sys_reserved: assert property (@(posedge clk) disable iff (srst)
      (system_control & ~SYSTEM_WRITABLE) == 8'h00) else $error("system reserved bits set");
   a_gate_reserved: assert property (@(posedge clk) disable iff (srst)
      (module_clock_gate & ~GATE_WRITABLE) == 8'h00) else $error("gate reserved bits set");
   a_gate_key: assert property (@(posedge clk) disable iff (rst_any)
      (bus_write && hit_gate && bus_size == PDC_SZ_WORD && bus_wdata[15:8] == GATE_WRITE_KEY)
      |=> module_clock_gate == ($past(bus_wdata[7:0]) & GATE_WRITABLE)) else $error("keyed write lost");
   a_gate_nokey: assert property (@(posedge clk) disable iff (rst_any)
      (bus_write && hit_gate && (bus_size != PDC_SZ_WORD || bus_wdata[15:8] != GATE_WRITE_KEY))
      |=> $stable(module_clock_gate)) else $error("unkeyed write changed gate");
   a_ram_gate: assert property (@(posedge clk) disable iff (srst)
      !system_control[RAM_ENABLE_BIT] |-> !ram_sel && !ram_we) else $error("ram served while disabled");
   a_dbg_reset: assert property (@(posedge clk) disable iff (srst)
      system_control[DEBUG_RESET_BIT] |-> debug_unit_reset) else $error("debug reset not held");
   a_break_stop: assert property (@(posedge clk) disable iff (srst)
      module_clock_gate[BREAK_STOP_BIT] |-> !break_clock_en && break_unit_reset) else $error("break unit running");
   a_dbg_stop: assert property (@(posedge clk) disable iff (srst)
      module_clock_gate[DEBUG_STOP_BIT] |-> !debug_clock_en) else $error("debug clock running");
   a_hw_entry: assert property (@(posedge clk) disable iff (srst)
      !hw_standby_n |-> ##3 hw_standby) else $error("standby not entered");
   a_reset_load: assert property (@(posedge clk) disable iff (srst)
      hw_standby |=> standby_control == STANDBY_CONTROL_RST) else $error("standby reset value wrong");
   a_float_out: assert property (@(posedge clk) disable iff (srst)
      ports_float |-> soft_standby && standby_control[PORT_FLOAT_BIT]) else $error("ports float outside standby");
   a_osc_start: assert property (@(posedge clk) disable iff (srst)
      (pwr_state == PDC_OSC_START) |-> osc_enable && cpu_reset) else $error("oscillator state wrong");
   c_soft_entry: cover property (@(posedge clk) disable iff (srst) $rose(soft_standby));
   c_sleep_entry: cover property (@(posedge clk) disable iff (srst) $rose(sleep_mode));
   c_gate_write: cover property (@(posedge clk) disable iff (srst)
      bus_write && hit_gate && bus_wdata[15:8] == GATE_WRITE_KEY);
   c_hw_exit: cover property (@(posedge clk) disable iff (srst)
      pwr_state == PDC_OSC_START ##1 pwr_state == PDC_RUN);
endmodule
`default_nettype wire

// [pkg/pdc_pkg.sv]
// power-down control package: register map, reset values, field positions
package pdc_pkg;
   // ----------------------------------------
   // register addresses (byte addresses)
   // ----------------------------------------
   localparam logic [31:0] STANDBY_CONTROL_ADDR   = 32'hFFFFEC14;
   localparam logic [31:0] SYSTEM_CONTROL_ADDR    = 32'hFFFFF708;
   localparam logic [31:0] MODULE_CLOCK_GATE_ADDR = 32'hFFFFF70A;
   // ----------------------------------------
   // reset values and write masks
   // ----------------------------------------
   localparam logic [7:0] STANDBY_CONTROL_RST   = 8'h1F;
   localparam logic [7:0] SYSTEM_CONTROL_RST    = 8'h01;
   localparam logic [7:0] MODULE_CLOCK_GATE_RST = 8'h01;
   localparam logic [7:0] STANDBY_FIXED_ONES    = 8'h1F;
   localparam logic [7:0] STANDBY_WRITABLE      = 8'hC0;
   localparam logic [7:0] SYSTEM_WRITABLE       = 8'h03;
   localparam logic [7:0] GATE_WRITABLE         = 8'h09;
   localparam logic [7:0] GATE_WRITE_KEY        = 8'h3C;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SOFT_STANDBY_BIT = 7;
   localparam int PORT_FLOAT_BIT   = 6;
   localparam int DEBUG_RESET_BIT  = 1;
   localparam int RAM_ENABLE_BIT   = 0;
   localparam int DEBUG_STOP_BIT   = 3;
   localparam int BREAK_STOP_BIT   = 0;
   // ----------------------------------------
   // access sizes and power states
   // ----------------------------------------
   typedef enum logic [1:0] {
      PDC_SZ_BYTE = 2'b00,
      PDC_SZ_WORD = 2'b01,
      PDC_SZ_LONG = 2'b10
   } pdc_size_t;
   typedef enum logic [1:0] {
      PDC_HW_STANDBY = 2'b00,
      PDC_OSC_START  = 2'b01,
      PDC_RUN        = 2'b10
   } pdc_pwr_t;
endpackage

// [pkg/pdc_ctl_if.sv]
// control bundle between register file and power sequencer
`timescale 1ns/1ps
`default_nettype none
interface pdc_ctl_if;
   logic soft_standby_select;
   logic port_float_select;
   logic in_reset;
   modport regs (output soft_standby_select, output port_float_select, input in_reset);
   modport seq  (input soft_standby_select, input port_float_select, output in_reset);
endinterface
`default_nettype wire

// [core/pdc_sync.sv]
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module pdc_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic d,
   output logic      q
);
   logic meta;
   logic next_meta;
   logic next_q;
   // ------------------------------
   // next values
   // ------------------------------
   always_comb begin
      next_meta = d;
      next_q    = meta;
   end
   // first stage read only by the second
   always_ff @(posedge clk) begin
      if (srst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule
`default_nettype wire

// [core/pdc_sequencer.sv]
// hardware standby entry/exit sequencer
`timescale 1ns/1ps
`default_nettype none
module pdc_sequencer
   import pdc_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic hw_standby_n,
   input  wire logic chip_init_n,
   input  wire logic sleep_req,
   pdc_ctl_if.seq    ctl,
   output logic      osc_enable,
   output logic      hw_standby,
   output logic      soft_standby,
   output logic      sleep_mode,
   output logic      ports_float,
   output pdc_pwr_t  pwr_state
);
   // standby and init pins pass through the sync stage in the top
   pdc_pwr_t next_pwr;
   logic     next_soft;
   logic     next_sleep;
   // ------------------------------
   // power state next values
   // ------------------------------
   always_comb begin
      next_pwr   = pwr_state;
      next_soft  = soft_standby;
      next_sleep = sleep_mode;
      if (!hw_standby_n) begin
         next_pwr   = PDC_HW_STANDBY;
         next_soft  = 1'b0;
         next_sleep = 1'b0;
      end else if (!chip_init_n) begin
         next_pwr   = PDC_OSC_START;
         next_soft  = 1'b0;
         next_sleep = 1'b0;
      end else begin
         next_pwr = PDC_RUN;
         if (pwr_state == PDC_RUN && sleep_req && !soft_standby && !sleep_mode) begin
            next_soft  = ctl.soft_standby_select;
            next_sleep = !ctl.soft_standby_select;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pwr_state    <= PDC_HW_STANDBY;
         soft_standby <= 1'b0;
         sleep_mode   <= 1'b0;
      end else begin
         pwr_state    <= next_pwr;
         soft_standby <= next_soft;
         sleep_mode   <= next_sleep;
      end
   end
   // derived outputs
   assign osc_enable = (pwr_state != PDC_HW_STANDBY);
   assign hw_standby = (pwr_state == PDC_HW_STANDBY);
   assign ctl.in_reset = (pwr_state != PDC_RUN);
   // float ports only in software standby
   assign ports_float = soft_standby && ctl.port_float_select;
endmodule
`default_nettype wire

// [verif/pdc_supervisor.sv]
// behavioural model of the external supervisor that drives the standby and init pins
`timescale 1ns/1ps
`default_nettype none
module pdc_supervisor #(
   parameter int OSC_WAIT = 8
) (
   input  wire logic clk,
   input  wire logic standby_req,
   output logic      hw_standby_n,
   output logic      chip_init_n
);
   // ----------------------------------------
   // pin sequencing
   // ----------------------------------------
   // pins start high so the block can leave reset; changes land off the clock edge
   initial begin
      hw_standby_n = 1'b1;
      chip_init_n  = 1'b1;
      forever begin
         @(posedge standby_req);
         #1 chip_init_n = 1'b0;
         repeat (2) @(posedge clk);
         #1 hw_standby_n = 1'b0;
         @(negedge standby_req);
         #1 hw_standby_n = 1'b1;
         // oscillator settle time is modelled only as a cycle count
         repeat (OSC_WAIT) @(posedge clk);
         #1 chip_init_n = 1'b1;
      end
   end
endmodule
`default_nettype wire

// [verif/power_down_control_tb_top.sv]
// self-checking bench for the power-down control block
`timescale 1ns/1ps
`default_nettype none
module power_down_control_tb_top;
   import pdc_pkg::*;
   // ----------------------------------------
   // signals and table
   // ----------------------------------------
   typedef struct packed {
      logic        wd;
      logic        wr;
      logic [31:0] addr;
      pdc_size_t   sz;
      logic [15:0] data;
      logic [7:0]  exp;
   } pdc_row_t;
   localparam logic [31:0] SB = STANDBY_CONTROL_ADDR;
   localparam logic [31:0] SY = SYSTEM_CONTROL_ADDR;
   localparam logic [31:0] GT = MODULE_CLOCK_GATE_ADDR;
   // writes answer 00; a read follows every write but the long-size one to prove what was kept
   localparam pdc_row_t ROWS [17] = '{
      '{1'b0, 1'b0, SB, PDC_SZ_BYTE, 16'h0000, 8'h1F},
      '{1'b0, 1'b0, SY, PDC_SZ_BYTE, 16'h0000, 8'h01},
      '{1'b0, 1'b0, GT, PDC_SZ_BYTE, 16'h0000, 8'h01},
      '{1'b0, 1'b0, 32'hFFFFF700, PDC_SZ_BYTE, 16'h0000, 8'h00},
      '{1'b1, 1'b1, SB, PDC_SZ_BYTE, 16'h00C0, 8'h00},
      '{1'b1, 1'b0, SB, PDC_SZ_BYTE, 16'h0000, 8'h1F},
      '{1'b0, 1'b1, GT, PDC_SZ_BYTE, 16'h0008, 8'h00},
      '{1'b0, 1'b0, GT, PDC_SZ_BYTE, 16'h0000, 8'h01},
      '{1'b0, 1'b1, GT, PDC_SZ_WORD, 16'h5508, 8'h00},
      '{1'b0, 1'b0, GT, PDC_SZ_BYTE, 16'h0000, 8'h01},
      '{1'b0, 1'b1, GT, PDC_SZ_LONG, 16'h3C08, 8'h00},
      '{1'b0, 1'b1, GT, PDC_SZ_WORD, 16'h3CFF, 8'h00},
      '{1'b0, 1'b0, GT, PDC_SZ_BYTE, 16'h0000, 8'h09},
      '{1'b0, 1'b1, SY, PDC_SZ_BYTE, 16'h00FF, 8'h00},
      '{1'b0, 1'b0, SY, PDC_SZ_BYTE, 16'h0000, 8'h03},
      '{1'b0, 1'b1, SB, PDC_SZ_BYTE, 16'h00FF, 8'h00},
      '{1'b0, 1'b0, SB, PDC_SZ_BYTE, 16'h0000, 8'hDF}
   };
   logic        clk, srst, watchdog_run, sleep_req, bus_req, bus_write, ram_req, ram_write, standby_req;
   logic [31:0] bus_addr;
   pdc_size_t   bus_size;
   logic [15:0] bus_wdata;
   logic [7:0]  bus_rdata, rd;
   logic        bus_ack, ram_sel, ram_we, debug_unit_reset, debug_clock_en, break_clock_en, break_unit_reset;
   logic        osc_enable, hw_standby, soft_standby, sleep_mode, ports_float, cpu_reset;
   wire logic   hw_standby_n, chip_init_n;
   int          err_total = 0;
   int          n_checks  = 0;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   pdc_top i_dut (.clk(clk), .srst(srst), .hw_standby_n(hw_standby_n), .chip_init_n(chip_init_n),
      .watchdog_run(watchdog_run), .sleep_req(sleep_req), .bus_req(bus_req), .bus_write(bus_write),
      .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .bus_ack(bus_ack), .ram_req(ram_req), .ram_write(ram_write), .ram_sel(ram_sel), .ram_we(ram_we),
      .debug_unit_reset(debug_unit_reset), .debug_clock_en(debug_clock_en), .break_clock_en(break_clock_en),
      .break_unit_reset(break_unit_reset), .osc_enable(osc_enable), .hw_standby(hw_standby),
      .soft_standby(soft_standby), .sleep_mode(sleep_mode), .ports_float(ports_float), .cpu_reset(cpu_reset));
   pdc_supervisor #(.OSC_WAIT(8)) i_sup (.clk(clk), .standby_req(standby_req),
      .hw_standby_n(hw_standby_n), .chip_init_n(chip_init_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one request, held until the edge that takes it; answer sampled just after that same edge
   task automatic bus_op(input logic wr, input logic [31:0] a, input pdc_size_t s, input logic [15:0] d,
                         output logic [7:0] r);
      @(posedge clk);
      #1 bus_req = 1'b1;
      bus_write = wr;
      bus_addr = a;
      bus_size = s;
      bus_wdata = d;
      @(posedge clk);
      #1 bus_req = 1'b0;
      r = bus_rdata;
      chk({7'h00, bus_ack}, 8'h01, "ack");
   endtask
   task automatic pulse_sleep();
      @(posedge clk);
      #1 sleep_req = 1'b1;
      @(posedge clk);
      #1 sleep_req = 1'b0;
   endtask
   // bounded wait for the chip to reach the run state
   task automatic wait_run();
      for (int i = 0; i < 20 && cpu_reset !== 1'b0; i++) @(posedge clk);
      #1 chk({7'h00, cpu_reset}, 8'h00, "run reached");
   endtask
   task automatic conclude();
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // whole run is under a hundred cycles; this cuts a hang long after that
   initial begin
      #100us;
      err_total++;
      conclude();
   end
   initial begin
      srst = 1'b1; watchdog_run = 1'b0; sleep_req = 1'b0; bus_req = 1'b0; bus_write = 1'b0;
      bus_addr = 32'h0; bus_size = PDC_SZ_BYTE; bus_wdata = 16'h0; ram_req = 1'b1; ram_write = 1'b1;
      standby_req = 1'b0;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      wait_run();
      foreach (ROWS[i]) begin
         watchdog_run = ROWS[i].wd;
         bus_op(ROWS[i].wr, ROWS[i].addr, ROWS[i].sz, ROWS[i].data, rd);
         chk(rd, ROWS[i].exp, "table row");
      end
      // system 03 and gate 09: debug held, both clocks stopped, RAM served
      chk({4'h0, debug_unit_reset, debug_clock_en, break_clock_en, break_unit_reset}, 8'h09, "units");
      chk({6'h00, ram_sel, ram_we}, 8'h03, "ram on");
      bus_op(1'b1, SY, PDC_SZ_BYTE, 16'h0000, rd);
      bus_op(1'b1, GT, PDC_SZ_WORD, 16'h3C00, rd);
      chk({4'h0, debug_unit_reset, debug_clock_en, break_clock_en, break_unit_reset}, 8'h06, "units");
      chk({6'h00, ram_sel, ram_we}, 8'h00, "ram off");
      // standby bit7 and bit6 are set: sleep request lands in floating soft standby
      pulse_sleep();
      chk({5'h00, soft_standby, sleep_mode, ports_float}, 8'h05, "soft standby");
      standby_req = 1'b1;
      for (int i = 0; i < 20 && hw_standby !== 1'b1; i++) @(posedge clk);
      #1 chk({6'h00, hw_standby, osc_enable}, 8'h02, "hw standby");
      standby_req = 1'b0;
      repeat (6) @(posedge clk);
      #1 chk({6'h00, osc_enable, cpu_reset}, 8'h03, "osc before init");
      wait_run();
      chk({5'h00, soft_standby, sleep_mode, ports_float}, 8'h00, "modes cleared");
      bus_op(1'b0, SB, PDC_SZ_BYTE, 16'h0000, rd);
      chk(rd, 8'h1F, "standby reload");
      bus_op(1'b0, GT, PDC_SZ_BYTE, 16'h0000, rd);
      chk(rd, 8'h01, "gate reload");
      chk({7'h00, ram_sel}, 8'h01, "ram reload");
      pulse_sleep();
      chk({5'h00, soft_standby, sleep_mode, ports_float}, 8'h02, "sleep");
      // ram off then on again, with the read of system control right after the enabling write
      bus_op(1'b1, SY, PDC_SZ_BYTE, 16'h0000, rd);
      chk({6'h00, ram_sel, ram_we}, 8'h00, "ram off again");
      bus_op(1'b1, SY, PDC_SZ_BYTE, 16'h0001, rd);
      bus_op(1'b0, SY, PDC_SZ_BYTE, 16'h0000, rd);
      chk(rd, 8'h01, "ram enable read back");
      chk({6'h00, ram_sel, ram_we}, 8'h03, "ram on again");
      conclude();
   end
endmodule
`default_nettype wire
